// File: verilog/lc_pkg.sv
// Shared constants, types and register map of the light curtain control
package lc_pkg;
  // ==========================================================
  // Timebase
  localparam int CLK_HZ   = 100_000_000;
  localparam int TICK_CYC = CLK_HZ / 1000;
  // ==========================================================
  // Times in milliseconds
  localparam logic [15:0] PRESS_MIN_MS = 16'h0096;
  localparam logic [15:0] PRESS_MAX_MS = 16'h0FA0;
  localparam logic [15:0] GATE_WAIT_MS = 16'h0FA0;
  localparam logic [15:0] SYNC_LOSS_MS = 16'hEA60;
  localparam logic [15:0] FLASH_MS     = 16'h00FA;
  // ==========================================================
  // Beams and blanking
  localparam int          NBEAMS    = 32;
  localparam int          SYNC_LO   = 0;
  localparam int          SYNC_HI   = NBEAMS - 1;
  localparam logic [5:0]  MAX_AREAS = 6'h0A;
  // ==========================================================
  // Register map
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_BLANK  = 8'h04;
  localparam logic [7:0]  ADDR_STATUS = 8'h08;
  localparam int          CTRL_BLANK_EN = 0;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] BLANK_RESET = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_BOOT  = 2'h0,
    ST_LOCK  = 2'h1,
    ST_ON    = 2'h2,
    ST_STRAP = 2'h3
  } state_t;

  typedef struct packed {
    logic [22:0] rsvd;
    logic        gate_fault;
    logic        sync_lost;
    logic        cfg_err;
    logic        chan_mismatch;
    logic        tx_chan;
    logic        rx_chan;
    logic        safety_switch_outputs;
    state_t      state;
  } status_t;
endpackage

// File: verilog/lc_control.sv
// Receiver function control: interlock, channel, range, signal, blanking
// Function
// - Once the field was entered and cleared, outputs stay OFF.
// - After power returns the outputs start OFF with no auto start.
// - A reset press released after 0.15 s to 4 s switches ON.
// - The restart interlock is always active, with no setting.
// - Factory default is the first transmission channel.
// - A strap at power-up toggles to channel two; remove and repower.
// - Each strap procedure alternates the stored channel.
// - The transmitter channel follows its supply polarity.
// - Range pin unwired gives reduced power, wired gives full power.
// - Signal output is steady high while gating runs without errors.
// - Signal output flashes on faulty gating, e.g. no entry in 4 s.
// - With blanking on, missing blanked objects force outputs OFF.
// - Up to 10 fixed blanked areas of adjacent beams are allowed.
// - At least one synchronisation beam must stay unblanked.
// - Sync beams lost for over 60 s switch the outputs OFF.
module lc_control #(
  parameter int TICK_CYC = lc_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        NRST,
  // Field and operator pins
  input  wire logic [31:0] BEAM_INT,
  input  wire logic        RESET_BTN,
  input  wire logic        CHAN_STRAP,
  input  wire logic        RANGE_WIRED,
  input  wire logic        TX_POL_REV,
  input  wire logic        GATE_REQ,
  input  wire logic        GATE_ACTIVE,
  // Stored channel selection
  input  wire logic        NV_CHAN,
  output logic             NV_WR,
  output logic             NV_DATA,
  // Outputs
  output logic             SAFETY_SWITCH_OUTPUTS,
  output logic             SIGNAL_OUT,
  output logic             TX_FULL_POWER,
  output logic             SECOND_TX_CHANNEL,
  // AXI4-Lite
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY
);
  // ==========================================================
  // Reset release and pin synchronisers
  logic [1:0]  rst_sync_q;
  logic        rst_n;
  logic [38:0] pin_s1_q;
  logic [38:0] pin_s2_q;
  logic [31:0] beam;
  logic        btn;
  logic        strap;
  logic        range_w;
  logic        tx_pol;
  logic        g_req;
  logic        g_act;
  logic        nv_chan;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 39'h0_0000_0000;
      pin_s2_q <= 39'h0_0000_0000;
    end else begin
      pin_s1_q <= {nv_in(NV_CHAN), GATE_ACTIVE, GATE_REQ, TX_POL_REV,
                   RANGE_WIRED, CHAN_STRAP, RESET_BTN, BEAM_INT};
      pin_s2_q <= pin_s1_q;
    end
  end
  assign {nv_chan, g_act, g_req, tx_pol, range_w, strap, btn, beam}
    = pin_s2_q;

  function automatic logic nv_in(input logic v);
    return v;
  endfunction

  // ==========================================================
  // Millisecond tick
  logic [16:0] div_q;
  logic        tick;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) div_q <= 17'h0_0000;
    else if (tick) div_q <= 17'h0_0000;
    else div_q <= div_q + 17'h0_0001;
  end
  assign tick = (div_q == 17'(TICK_CYC - 1));

  // ==========================================================
  // Registers
  logic [31:0] ctrl_q;
  logic [31:0] blank_q;
  logic        blank_en;
  assign blank_en = ctrl_q[lc_pkg::CTRL_BLANK_EN];

  // Number of separate runs of blanked beams
  function automatic logic [5:0] area_count(input logic [31:0] m);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < lc_pkg::NBEAMS; i++) begin
      if (m[i] && (i == 0 || !m[i-1])) n = n + 6'h01;
    end
    return n;
  endfunction

  logic cfg_err;
  logic field_viol;
  logic obj_missing;
  assign cfg_err = blank_en &&
    ((area_count(blank_q) > lc_pkg::MAX_AREAS) ||
     (blank_q[lc_pkg::SYNC_LO] && blank_q[lc_pkg::SYNC_HI]));
  assign field_viol  = |(beam & ~(blank_en ? blank_q : 32'h0000_0000));
  assign obj_missing = blank_en && |(blank_q & ~beam);

  // ==========================================================
  // Reset button press timing
  logic [15:0] press_q;
  logic        btn_q;
  logic        press_ok;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) btn_q <= 1'b0;
    else btn_q <= btn;
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) press_q <= 16'h0000;
    else if (!btn) press_q <= 16'h0000;
    else if (tick && press_q <= lc_pkg::PRESS_MAX_MS)
      press_q <= press_q + 16'h0001;
  end
  // Release edge with duration in window; others ignored
  assign press_ok = btn_q && !btn &&
                    press_q >= lc_pkg::PRESS_MIN_MS &&
                    press_q <= lc_pkg::PRESS_MAX_MS;

  // ==========================================================
  // Synchronisation beam loss
  logic [15:0] sync_q;
  logic        sync_lost;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) sync_q <= 16'h0000;
    else if (!(beam[lc_pkg::SYNC_LO] && beam[lc_pkg::SYNC_HI]))
      sync_q <= 16'h0000;
    else if (tick && !sync_lost) sync_q <= sync_q + 16'h0001;
  end
  assign sync_lost = (sync_q > lc_pkg::SYNC_LOSS_MS);

  // ==========================================================
  // Interlock state machine
  lc_pkg::state_t state_q;
  lc_pkg::state_t state_d;
  logic [1:0]     boot_q;
  logic           chan_q;
  logic           nv_wr_q;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) boot_q <= 2'h0;
    else if (boot_q != 2'h3) boot_q <= boot_q + 2'h1;
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      // Strap is read only once the synchronisers hold settled pins
      lc_pkg::ST_BOOT: begin
        if (boot_q == 2'h3)
          state_d = strap ? lc_pkg::ST_STRAP : lc_pkg::ST_LOCK;
      end
      lc_pkg::ST_LOCK: begin
        if (press_ok && !field_viol && !obj_missing && !cfg_err &&
            !sync_lost)
          state_d = lc_pkg::ST_ON;
      end
      lc_pkg::ST_ON: begin
        // Always falls back to interlock, never to auto release
        if (field_viol || obj_missing || cfg_err || sync_lost)
          state_d = lc_pkg::ST_LOCK;
      end
      lc_pkg::ST_STRAP: state_d = lc_pkg::ST_STRAP;
      default: state_d = lc_pkg::ST_LOCK;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) state_q <= lc_pkg::ST_BOOT;
    else state_q <= state_d;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      chan_q  <= 1'b0;
      nv_wr_q <= 1'b0;
    end else begin
      nv_wr_q <= 1'b0;
      if (state_q == lc_pkg::ST_BOOT && boot_q == 2'h3) begin
        chan_q  <= strap ? !nv_chan : nv_chan;
        nv_wr_q <= strap;
      end
    end
  end

  // ==========================================================
  // Gating signal output
  logic [15:0] gwait_q;
  logic        gate_fault;
  logic [15:0] flash_q;
  logic        flash_lvl_q;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) gwait_q <= 16'h0000;
    else if (!g_req || field_viol) gwait_q <= 16'h0000;
    else if (tick && !gate_fault) gwait_q <= gwait_q + 16'h0001;
  end
  assign gate_fault = (gwait_q >= lc_pkg::GATE_WAIT_MS);
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      flash_q     <= 16'h0000;
      flash_lvl_q <= 1'b0;
    end else if (tick) begin
      if (flash_q == lc_pkg::FLASH_MS - 16'h0001) begin
        flash_q     <= 16'h0000;
        flash_lvl_q <= !flash_lvl_q;
      end else begin
        flash_q <= flash_q + 16'h0001;
      end
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) SIGNAL_OUT <= 1'b0;
    else if (gate_fault) SIGNAL_OUT <= flash_lvl_q;
    else SIGNAL_OUT <= g_act;
  end

  // ==========================================================
  // Pin outputs
  // Transmitter settings carry no safety monitoring
  assign SAFETY_SWITCH_OUTPUTS = (state_q == lc_pkg::ST_ON);
  assign TX_FULL_POWER     = range_w;
  assign SECOND_TX_CHANNEL = chan_q;
  assign NV_WR             = nv_wr_q;
  assign NV_DATA           = chan_q;

  lc_pkg::status_t status;
  always_comb begin
    status               = '0;
    status.gate_fault    = gate_fault;
    status.sync_lost     = sync_lost;
    status.cfg_err       = cfg_err;
    status.tx_chan       = tx_pol;
    status.chan_mismatch = tx_pol != chan_q;
    status.rx_chan       = chan_q;
    status.safety_switch_outputs          = SAFETY_SWITCH_OUTPUTS;
    status.state         = state_q;
  end

  // ==========================================================
  // AXI4-Lite slave
  logic       aw_q;
  logic       w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    for (int b = 0; b < 4; b++) if (s[b]) o[b*8 +: 8] = n[b*8 +: 8];
    return o;
  endfunction

  assign AWREADY = !aw_q && !BVALID;
  assign WREADY  = !w_q && !BVALID;
  assign ARREADY = !RVALID;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_q <= 1'b0;
      w_q  <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (aw_q && w_q) begin
      aw_q <= 1'b0;
      w_q  <= 1'b0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_q <= 1'b1;
        awaddr_q <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_q <= 1'b1;
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q  <= lc_pkg::CTRL_RESET;
      blank_q <= lc_pkg::BLANK_RESET;
      BVALID  <= 1'b0;
      BRESP   <= lc_pkg::RESP_OKAY;
    end else if (aw_q && w_q) begin
      BVALID <= 1'b1;
      BRESP  <= lc_pkg::RESP_OKAY;
      case (awaddr_q)
        lc_pkg::ADDR_CTRL:
          ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_0001;
        lc_pkg::ADDR_BLANK: blank_q <= merge(blank_q, wdata_q, wstrb_q);
        lc_pkg::ADDR_STATUS: BRESP <= lc_pkg::RESP_OKAY;
        default: BRESP <= lc_pkg::RESP_SLVERR;
      endcase
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0000_0000;
      RRESP  <= lc_pkg::RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RRESP  <= lc_pkg::RESP_OKAY;
      case (ARADDR)
        lc_pkg::ADDR_CTRL:   RDATA <= ctrl_q;
        lc_pkg::ADDR_BLANK:  RDATA <= blank_q;
        lc_pkg::ADDR_STATUS: RDATA <= status;
        default: begin
          RDATA <= 32'h0000_0000;
          RRESP <= lc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // ==========================================================
  // Assertions
  property p_field_drop;
    @(posedge CLK) disable iff (!rst_n)
    (state_q == lc_pkg::ST_ON && field_viol) |=> !SAFETY_SWITCH_OUTPUTS;
  endproperty
  a_field_drop: assert property (p_field_drop)
    else $error("outputs stayed on after field entry");

  property p_no_auto;
    @(posedge CLK) disable iff (!rst_n)
    $rose(SAFETY_SWITCH_OUTPUTS) |-> $past(press_ok);
  endproperty
  a_no_auto: assert property (p_no_auto)
    else $error("outputs released without a valid press");

  property p_boot_off;
    @(posedge CLK) disable iff (!rst_n)
    (state_q == lc_pkg::ST_BOOT) |-> !SAFETY_SWITCH_OUTPUTS;
  endproperty
  a_boot_off: assert property (p_boot_off)
    else $error("outputs on during start-up");

  property p_press_on;
    @(posedge CLK) disable iff (!rst_n)
    (state_q == lc_pkg::ST_LOCK && press_ok && !field_viol &&
     !obj_missing && !cfg_err && !sync_lost) |=> SAFETY_SWITCH_OUTPUTS;
  endproperty
  a_press_on: assert property (p_press_on)
    else $error("valid press did not switch on");

  property p_short_press;
    @(posedge CLK) disable iff (!rst_n)
    (btn_q && !btn && press_q < lc_pkg::PRESS_MIN_MS &&
     state_q == lc_pkg::ST_LOCK) |=> !SAFETY_SWITCH_OUTPUTS;
  endproperty
  a_short_press: assert property (p_short_press)
    else $error("short press released the interlock");

  property p_strap_chan;
    @(posedge CLK) disable iff (!rst_n)
    (state_q == lc_pkg::ST_BOOT && boot_q == 2'h3)
      |=> (SECOND_TX_CHANNEL == ($past(strap) ^ $past(nv_chan))) &&
          (NV_WR == $past(strap));
  endproperty
  a_strap_chan: assert property (p_strap_chan)
    else $error("channel not alternated by strap");

  property p_strap_hold;
    @(posedge CLK) disable iff (!rst_n)
    (state_q == lc_pkg::ST_STRAP) |=> (state_q == lc_pkg::ST_STRAP) &&
                                      !SAFETY_SWITCH_OUTPUTS;
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("left strap state without power cycle");

  property p_range;
    @(posedge CLK) disable iff (!rst_n)
    // Pin passes both synchroniser stages before it reaches the output
    $past(rst_n, 2) |-> TX_FULL_POWER == $past(RANGE_WIRED, 2);
  endproperty
  a_range: assert property (p_range)
    else $error("transmit power does not follow range pin");

  property p_signal;
    @(posedge CLK) disable iff (!rst_n)
    (!gate_fault && g_act) |=> SIGNAL_OUT;
  endproperty
  a_signal: assert property (p_signal)
    else $error("signal low during good gating");

  property p_flash;
    @(posedge CLK) disable iff (!rst_n)
    (gate_fault && $changed(flash_lvl_q)) |=> SIGNAL_OUT == $past(flash_lvl_q);
  endproperty
  a_flash: assert property (p_flash)
    else $error("signal not flashing on gating fault");

  property p_blank_obj;
    @(posedge CLK) disable iff (!rst_n)
    (obj_missing || cfg_err) |=> !SAFETY_SWITCH_OUTPUTS;
  endproperty
  a_blank_obj: assert property (p_blank_obj)
    else $error("outputs on with blanked object missing");

  property p_sync;
    @(posedge CLK) disable iff (!rst_n)
    sync_lost |=> !SAFETY_SWITCH_OUTPUTS;
  endproperty
  a_sync: assert property (p_sync)
    else $error("outputs on after sync loss");

  c_on:    cover property (@(posedge CLK) disable iff (!rst_n)
    $rose(SAFETY_SWITCH_OUTPUTS));
  c_strap: cover property (@(posedge CLK) disable iff (!rst_n)
    state_q == lc_pkg::ST_STRAP);
  c_fault: cover property (@(posedge CLK) disable iff (!rst_n)
    $rose(gate_fault));
endmodule

// File: testbench/lc_far_side.sv
// Far-side model: reset button, gating control, transmitter, channel store
module lc_far_side #(
  parameter int TICK_CYC = 2
) (
  // Clock
  input  wire logic CLK,
  // Stored channel write from the receiver
  input  wire logic NV_WR,
  input  wire logic NV_DATA,
  output logic      NV_CHAN,
  // Operator, control and transmitter
  output logic      RESET_BTN,
  output logic      GATE_REQ,
  output logic      GATE_ACTIVE,
  output logic      TX_POL_REV
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Channel store, factory value is channel one
  initial begin
    NV_CHAN     = 1'b0;
    RESET_BTN   = 1'b0;
    GATE_REQ    = 1'b0;
    GATE_ACTIVE = 1'b0;
    TX_POL_REV  = 1'b0;
  end
  // Survives receiver resets, like a real store across power cycles
  always @(posedge CLK) begin
    if (NV_WR === 1'b1) begin
      NV_CHAN <= NV_DATA;
    end
  end

  // ==========================================================
  // Operator actions
  task automatic press(input int ticks);
    @(posedge CLK);
    RESET_BTN <= 1'b1;
    repeat (ticks * TICK_CYC) @(posedge CLK);
    RESET_BTN <= 1'b0;
  endtask

  task automatic set_gate(input logic req, input logic act);
    @(posedge CLK);
    GATE_REQ    <= req;
    GATE_ACTIVE <= act;
  endtask

  // Transmitter channel chosen by its supply polarity
  task automatic set_pol(input logic pol);
    @(posedge CLK);
    TX_POL_REV <= pol;
  endtask
endmodule

// File: testbench/tb_light_curtain_function_control.sv
// Self-checking bench of the light curtain function control
module tb_light_curtain_function_control;
  timeunit 1ns;
  timeprecision 1ps;
  // One tick a cycle keeps the long sync-loss run inside the budget
  localparam int TICK = 1;

  // ==========================================================
  // Signals
  logic        CLK, NRST, CHAN_STRAP, RANGE_WIRED;
  logic [31:0] BEAM_INT;
  logic        RESET_BTN, GATE_REQ, GATE_ACTIVE, TX_POL_REV;
  logic        NV_CHAN, NV_WR, NV_DATA;
  logic        SAFETY_SWITCH_OUTPUTS, SIGNAL_OUT;
  logic        TX_FULL_POWER, SECOND_TX_CHANNEL;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY;
  int          fails, total_checks;
  logic [31:0] d;
  logic [1:0]  r;

  lc_control #(.TICK_CYC(TICK)) i_dut (
    .CLK(CLK), .NRST(NRST), .BEAM_INT(BEAM_INT), .RESET_BTN(RESET_BTN),
    .CHAN_STRAP(CHAN_STRAP), .RANGE_WIRED(RANGE_WIRED),
    .TX_POL_REV(TX_POL_REV), .GATE_REQ(GATE_REQ),
    .GATE_ACTIVE(GATE_ACTIVE), .NV_CHAN(NV_CHAN), .NV_WR(NV_WR),
    .NV_DATA(NV_DATA), .SAFETY_SWITCH_OUTPUTS(SAFETY_SWITCH_OUTPUTS),
    .SIGNAL_OUT(SIGNAL_OUT), .TX_FULL_POWER(TX_FULL_POWER),
    .SECOND_TX_CHANNEL(SECOND_TX_CHANNEL), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY));

  lc_far_side #(.TICK_CYC(TICK)) i_far (
    .CLK(CLK), .NV_WR(NV_WR), .NV_DATA(NV_DATA), .NV_CHAN(NV_CHAN),
    .RESET_BTN(RESET_BTN), .GATE_REQ(GATE_REQ),
    .GATE_ACTIVE(GATE_ACTIVE), .TX_POL_REV(TX_POL_REV));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // ==========================================================
  // Reporting and comparison
  task automatic report_and_stop;
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // ==========================================================
  // Register bus master
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v,
                           output logic [1:0] resp);
    bit got;
    got = 1'b0;
    @(posedge CLK);
    AWADDR <= a; AWVALID <= 1'b1;
    WDATA <= v; WSTRB <= 4'hF; WVALID <= 1'b1; BREADY <= 1'b1;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge CLK);
      if (AWVALID && AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WVALID && WREADY === 1'b1) WVALID <= 1'b0;
      if (BVALID === 1'b1) begin
        resp = BRESP;
        got = 1'b1;
        BREADY <= 1'b0;
      end
    end
    if (!got) begin
      fails++;
      report_and_stop();
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v,
                          output logic [1:0] resp);
    bit got;
    got = 1'b0;
    @(posedge CLK);
    ARADDR <= a; ARVALID <= 1'b1; RREADY <= 1'b1;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge CLK);
      if (ARVALID && ARREADY === 1'b1) ARVALID <= 1'b0;
      if (RVALID === 1'b1) begin
        v = RDATA;
        resp = RRESP;
        got = 1'b1;
        RREADY <= 1'b0;
      end
    end
    if (!got) begin
      fails++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    axi_write(a, v, r);
    chk({30'h0, r}, {30'h0, lc_pkg::RESP_OKAY});
  endtask

  task automatic status_bit(input int i, input logic exp);
    axi_read(lc_pkg::ADDR_STATUS, d, r);
    chk_bit(d[i], exp);
  endtask

  // ==========================================================
  // Helpers
  task automatic set_beams(input logic [31:0] v);
    @(posedge CLK);
    BEAM_INT <= v;
    repeat (10) @(posedge CLK);
  endtask

  task automatic press_chk(input int ticks, input logic exp);
    i_far.press(ticks);
    repeat (10) @(posedge CLK);
    chk_bit(SAFETY_SWITCH_OUTPUTS, exp);
  endtask

  // Strap stays on well past the start-up sample, then is removed
  task automatic do_reset(input logic strap);
    @(posedge CLK);
    NRST <= 1'b0;
    CHAN_STRAP <= strap;
    repeat (5) @(posedge CLK);
    NRST <= 1'b1;
    repeat (20) @(posedge CLK);
    CHAN_STRAP <= 1'b0;
    repeat (5) @(posedge CLK);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    chk_bit(SAFETY_SWITCH_OUTPUTS, 1'b0);
    chk_bit(SECOND_TX_CHANNEL, 1'b0);
    @(posedge CLK);
    RANGE_WIRED <= 1'b1;
    repeat (5) @(posedge CLK);
    chk_bit(TX_FULL_POWER, 1'b1);
    RANGE_WIRED <= 1'b0;
    repeat (5) @(posedge CLK);
    chk_bit(TX_FULL_POWER, 1'b0);
    axi_read(lc_pkg::ADDR_CTRL, d, r);
    chk(d, lc_pkg::CTRL_RESET);
    axi_read(lc_pkg::ADDR_BLANK, d, r);
    chk(d, lc_pkg::BLANK_RESET);
    axi_read(lc_pkg::ADDR_STATUS, d, r);
    chk(d & 32'h0000_000F, 32'h0000_0001);
    wr(lc_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
    status_bit(2, 1'b0);
    axi_read(8'h0C, d, r);
    chk({30'h0, r}, {30'h0, lc_pkg::RESP_SLVERR});
    axi_write(8'h10, 32'h0000_0001, r);
    chk({30'h0, r}, {30'h0, lc_pkg::RESP_SLVERR});
  endtask

  task automatic t_interlock;
    press_chk(140, 1'b0);
    press_chk(152, 1'b1);
    set_beams(32'h0000_0100);
    chk_bit(SAFETY_SWITCH_OUTPUTS, 1'b0);
    set_beams(32'h0000_0000);
    chk_bit(SAFETY_SWITCH_OUTPUTS, 1'b0);
    press_chk(3995, 1'b1);
    set_beams(32'h0001_0000);
    set_beams(32'h0000_0000);
    press_chk(4010, 1'b0);
  endtask

  task automatic t_blank;
    wr(lc_pkg::ADDR_BLANK, 32'h0000_0020);
    wr(lc_pkg::ADDR_CTRL, 32'h0000_0001);
    press_chk(152, 1'b0);
    set_beams(32'h0000_0020);
    press_chk(152, 1'b1);
    set_beams(32'h0000_0000);
    chk_bit(SAFETY_SWITCH_OUTPUTS, 1'b0);
    wr(lc_pkg::ADDR_BLANK, 32'h8000_0001);
    status_bit(6, 1'b1);
    wr(lc_pkg::ADDR_BLANK, 32'h0015_5554);
    status_bit(6, 1'b0);
    axi_read(lc_pkg::ADDR_BLANK, d, r);
    chk(d, 32'h0015_5554);
    wr(lc_pkg::ADDR_BLANK, 32'h0055_5554);
    status_bit(6, 1'b1);
    wr(lc_pkg::ADDR_BLANK, 32'h0000_0000);
    wr(lc_pkg::ADDR_CTRL, 32'h0000_0000);
  endtask

  task automatic t_signal;
    logic s0;
    i_far.set_gate(1'b0, 1'b1);
    repeat (10) @(posedge CLK);
    chk_bit(SIGNAL_OUT, 1'b1);
    i_far.set_gate(1'b0, 1'b0);
    repeat (10) @(posedge CLK);
    chk_bit(SIGNAL_OUT, 1'b0);
    i_far.set_gate(1'b1, 1'b0);
    repeat ((4000 + 20) * TICK) @(posedge CLK);
    status_bit(8, 1'b1);
    @(posedge CLK);
    s0 = SIGNAL_OUT;
    repeat (250 * TICK) @(posedge CLK);
    chk_bit(SIGNAL_OUT, ~s0);
    repeat (250 * TICK) @(posedge CLK);
    chk_bit(SIGNAL_OUT, s0);
    i_far.set_gate(1'b0, 1'b0);
  endtask

  task automatic t_sync;
    set_beams(32'h8000_0001);
    repeat (59900 * TICK) @(posedge CLK);
    status_bit(7, 1'b0);
    repeat (200 * TICK) @(posedge CLK);
    status_bit(7, 1'b1);
    chk_bit(SAFETY_SWITCH_OUTPUTS, 1'b0);
    set_beams(32'h0000_0000);
    status_bit(7, 1'b0);
  endtask

  task automatic t_strap;
    do_reset(1'b1);
    chk_bit(SECOND_TX_CHANNEL, 1'b1);
    chk_bit(NV_CHAN, 1'b1);
    chk_bit(SAFETY_SWITCH_OUTPUTS, 1'b0);
    axi_read(lc_pkg::ADDR_STATUS, d, r);
    chk(d & 32'h0000_0003, 32'h0000_0003);
    do_reset(1'b0);
    chk_bit(SECOND_TX_CHANNEL, 1'b1);
    i_far.set_pol(1'b0);
    repeat (5) @(posedge CLK);
    status_bit(5, 1'b1);
    i_far.set_pol(1'b1);
    repeat (5) @(posedge CLK);
    status_bit(5, 1'b0);
    do_reset(1'b1);
    chk_bit(SECOND_TX_CHANNEL, 1'b0);
    do_reset(1'b0);
    chk_bit(SECOND_TX_CHANNEL, 1'b0);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    fails = 0;
    total_checks = 0;
    NRST = 1'b0; BEAM_INT = 32'h0; CHAN_STRAP = 1'b0; RANGE_WIRED = 1'b0;
    AWADDR = 8'h00; AWVALID = 1'b0; WDATA = 32'h0; WSTRB = 4'h0;
    WVALID = 1'b0; BREADY = 1'b0; ARADDR = 8'h00; ARVALID = 1'b0;
    RREADY = 1'b0;
    repeat (5) @(posedge CLK);
    NRST <= 1'b1;
    repeat (10) @(posedge CLK);
    t_regs();
    t_interlock();
    t_blank();
    t_signal();
    t_sync();
    t_strap();
    report_and_stop();
  end
endmodule
